// ==== rtl/wdt_watchdog_timer.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - watchdog runs right after reset release
// - control one resets enable1 time00 output1 traps1
// - interrupt selection is one-way until reset
// - overflow with reset selected pulls reset low
// - overflow with interrupt selected raises interrupt
// - uncleared counter overflows after detection time
// - stop idle sleep freeze the count
// - clear code clears counter, not divider
// - clear to overflow may be three quarters
// - time select picks divider tap per source
// - control one write-only, reads don't-care
// - command codes clear, disable, trap commit
// - disable code only when enable bit zero
// - enable zero alone does not stop
// - interrupt mode gives periodic interrupt
// - disabled watchdog holds counter cleared
// - watchdog interrupt is non-maskable
module wdt_watchdog_timer
   import wdt_pkg::*;
#(
   parameter int DIV_W = WDT_DIV_W
) (
   input  wire logic            clk_i,            // system clock, 40 MHz
   input  wire logic            rst_i,            // sync reset, active high
   input  wire logic            ce_i,             // clock enable, freezes all
   input  wire wdt_wb_req_type  wb_req_i,         // wishbone request
   output wdt_wb_rsp_type       wb_rsp_o,         // wishbone answer
   input  wire wdt_clk_ctl_type clk_ctl_i,        // source ticks and modes
   output logic                 wdt_reset_n_o,    // reset pin drive, low active
   output logic                 watchdog_interrupt_request_o, // nmi pulse
   output logic                 ram_trap_area_o,  // committed trap area select
   output logic                 trap_action_o     // trap action select
);

   generate
      if (DIV_W < 23) begin : g_chk
         $error("wdt_watchdog_timer: DIV_W too small");
      end
      // the quarter tap must sit inside the divider for every select
      if (int'(WDT_HF_TAP_TOP) >= DIV_W) begin : g_tap_chk
         $error("wdt_watchdog_timer: divider narrower than its top tap");
      end
      // a zero length would wrap the end compare to 31 and stretch the pulse to 32 cycles
      if (WDT_RST_PULSE_CYCLES == 5'h0) begin : g_pulse_chk
         $error("wdt_watchdog_timer: reset pulse length must be nonzero");
      end
   endgenerate

   wdt_state_type state_r;
   wdt_state_type state_nxt;

   logic       outsel_r;
   logic [1:0] tsel_r;
   logic       en_r;
   logic       trap_act_r;
   logic       trap_pend_r;
   logic       trap_area_r;
   logic       divsrc_r;
   logic [1:0] cnt_r;
   logic [4:0] pulse_cnt_r;
   logic       irq_r;
   logic       rst_n_r;

   logic       wr_stb;
   logic [7:0] wr_idx;
   logic [7:0] wr_data;
   logic [7:0] rd_data;
   logic       quarter;
   logic       use_lf;
   logic       tick;
   logic       self_init;
   logic       init;
   logic       wr_ctrl1;
   logic       wr_code;
   logic       wr_cfg;
   logic       code_clear;
   logic       code_disable;
   logic       overflow;
   logic       running;
   logic       in_pulse;
   logic       code_trap;
   logic [7:0] rd_idx;

   function automatic logic idx_is(input logic [7:0] idx, input logic [7:0] want);
      return idx == want;
   endfunction

   // command decode; any other byte on the code register is dropped
   function automatic logic code_is(input logic stb, input logic [7:0] data,
                                    input logic [7:0] want);
      return stb && (data == want);
   endfunction

   // bus slave
   wdt_wb_slave u_bus (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .ce_i      (ce_i),
      .req_i     (wb_req_i),
      .rd_data_i (rd_data),
      .rsp_o     (wb_rsp_o),
      .wr_stb_o  (wr_stb),
      .wr_idx_o  (wr_idx),
      .wr_data_o (wr_data)
   );

   // source choice: slow mode or low source bit uses the low clock
   assign use_lf = clk_ctl_i.slow_mode | divsrc_r;
   assign tick   = use_lf ? clk_ctl_i.lf_tick : clk_ctl_i.hf_tick;

   wdt_divider #(
      .DIV_W (DIV_W)
   ) u_div (
      .clk_i     (clk_i),
      .rst_i     (init),
      .ce_i      (ce_i),
      .tick_i    (tick),
      .hold_i    (clk_ctl_i.hold_mode),
      .use_lf_i  (use_lf),
      .tsel_i    (tsel_r),
      .quarter_o (quarter)
   );

   assign running  = (state_r == WDT_ST_RUN);
   assign in_pulse = (state_r == WDT_ST_RESET);

   // end of a reset pulse reinitialises the whole block except the bus slave
   assign self_init = ce_i & in_pulse
                      & (pulse_cnt_r == WDT_RST_PULSE_CYCLES - 5'h1);
   assign init      = rst_i | self_init;

   assign wr_ctrl1     = wr_stb & idx_is(wr_idx, WDT_CTRL1_IDX);
   assign wr_code      = wr_stb & idx_is(wr_idx, WDT_CODE_IDX);
   assign wr_cfg       = wr_stb & idx_is(wr_idx, WDT_CFG_IDX);
   assign code_clear   = code_is(wr_code, wr_data, WDT_CODE_CLEAR);
   // disable code has no effect while the enable bit is still set
   assign code_disable = code_is(wr_code, wr_data, WDT_CODE_DISABLE) & ~en_r;
   assign code_trap    = code_is(wr_code, wr_data, WDT_CODE_TRAP);
   assign overflow     = running & quarter & (cnt_r == 2'h3)
                         & ~code_clear;

   assign rd_idx = wb_req_i.adr[WDT_ADR_W-1:2];

   // write-only control registers read as zero; status shows live state
   always_comb begin
      rd_data = 8'h0;
      case (rd_idx)
         WDT_CFG_IDX: begin
            rd_data[WDT_DIVSRC_BIT] = divsrc_r;
         end
         WDT_STAT_IDX: begin
            rd_data[2:0] = state_r;
            rd_data[3]   = outsel_r;
            rd_data[5:4] = cnt_r;
            rd_data[6]   = en_r;
         end
         default: begin
            rd_data = 8'h0;
         end
      endcase
   end

   // watchdog_control_one fields, the committed trap area and the configuration source bit
   // once cleared the output select stays cleared
   always_ff @(posedge clk_i) begin
      if (init) begin
         outsel_r <= WDT_CTRL1_RST[WDT_OUTSEL_BIT];
      end else if (wr_ctrl1) begin
         outsel_r <= outsel_r & wr_data[WDT_OUTSEL_BIT];
      end
   end

   always_ff @(posedge clk_i) begin
      if (init) begin
         tsel_r <= WDT_CTRL1_RST[WDT_TSEL_LSB +: 2];
      end else if (wr_ctrl1) begin
         tsel_r <= wr_data[WDT_TSEL_LSB +: 2];
      end
   end

   // clearing the bit only arms the disable code
   always_ff @(posedge clk_i) begin
      if (init) begin
         en_r <= WDT_CTRL1_RST[WDT_EN_BIT];
      end else if (wr_ctrl1) begin
         en_r <= wr_data[WDT_EN_BIT];
      end
   end

   always_ff @(posedge clk_i) begin
      if (init) begin
         trap_act_r <= WDT_CTRL1_RST[WDT_TRAPACT_BIT];
      end else if (wr_ctrl1) begin
         trap_act_r <= wr_data[WDT_TRAPACT_BIT];
      end
   end

   always_ff @(posedge clk_i) begin
      if (init) begin
         trap_pend_r <= WDT_CTRL1_RST[WDT_TRAPAREA_BIT];
      end else if (wr_ctrl1) begin
         trap_pend_r <= wr_data[WDT_TRAPAREA_BIT];
      end
   end

   // trap area takes effect only after the commit code
   always_ff @(posedge clk_i) begin
      if (init) begin
         trap_area_r <= WDT_CTRL1_RST[WDT_TRAPAREA_BIT];
      end else if (code_trap) begin
         trap_area_r <= trap_pend_r;
      end
   end

   always_ff @(posedge clk_i) begin
      if (init) begin
         divsrc_r <= WDT_DIVSRC_RST;
      end else if (wr_cfg) begin
         divsrc_r <= wr_data[WDT_DIVSRC_BIT];
      end
   end

   // state machine
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         WDT_ST_RUN: begin
            if (code_disable) begin
               state_nxt = WDT_ST_OFF;
            end else if (overflow && outsel_r) begin
               state_nxt = WDT_ST_RESET;
            end
         end
         WDT_ST_OFF: begin
            if (wr_ctrl1 && wr_data[WDT_EN_BIT]) begin
               state_nxt = WDT_ST_RUN;
            end
         end
         WDT_ST_RESET: begin
            state_nxt = WDT_ST_RESET;
         end
         default: begin
            state_nxt = WDT_ST_RUN;
         end
      endcase
   end

   // runs from reset release with no software action
   always_ff @(posedge clk_i) begin
      if (init) begin
         state_r <= WDT_ST_RUN;
      end else if (ce_i) begin
         state_r <= state_nxt;
      end
   end

   // two-stage binary counter; phase within a quarter is the divider's,
   // so a clear may leave as little as three quarters
   always_ff @(posedge clk_i) begin
      if (init) begin
         cnt_r <= 2'h0;
      end else if (ce_i) begin
         if (!running) begin
            cnt_r <= 2'h0;
         end else if (code_clear) begin
            cnt_r <= 2'h0;
         end else if (quarter) begin
            cnt_r <= cnt_r + 2'h1;
         end
      end
   end

   // reset pin held low for a fixed count; it drops on the overflow edge
   // itself so the pin and the state agree from the first cycle
   always_ff @(posedge clk_i) begin
      if (init) begin
         rst_n_r <= 1'b1;
      end else if (ce_i && state_nxt == WDT_ST_RESET) begin
         rst_n_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (init) begin
         pulse_cnt_r <= 5'h0;
      end else if (ce_i && in_pulse) begin
         pulse_cnt_r <= pulse_cnt_r + 5'h1;
      end
   end

   // no mask term: the request cannot be gated off
   always_ff @(posedge clk_i) begin
      if (init) begin
         irq_r <= 1'b0;
      end else if (ce_i) begin
         irq_r <= overflow & ~outsel_r;
      end
   end

   assign wdt_reset_n_o                = rst_n_r;
   assign watchdog_interrupt_request_o = irq_r;
   assign ram_trap_area_o              = trap_area_r;
   assign trap_action_o                = trap_act_r;

endmodule

// ==== rtl/wdt_pkg.sv ====
package wdt_pkg;

   // register indices; byte address is four times the index
   localparam logic [7:0] WDT_CTRL1_IDX  = 8'h34;
   localparam logic [7:0] WDT_CODE_IDX   = 8'h35;
   localparam logic [7:0] WDT_CFG_IDX    = 8'h36;
   localparam logic [7:0] WDT_STAT_IDX   = 8'h37;
   localparam int         WDT_ADR_W      = 10;

   // watchdog_control_one fields
   localparam int         WDT_OUTSEL_BIT   = 0;
   localparam int         WDT_TSEL_LSB     = 1;
   localparam int         WDT_EN_BIT       = 3;
   localparam int         WDT_TRAPACT_BIT  = 4;
   localparam int         WDT_TRAPAREA_BIT = 5;
   localparam logic [7:0] WDT_CTRL1_RST    = 8'h39;

   // configuration register field
   localparam int         WDT_DIVSRC_BIT   = 4;
   localparam logic       WDT_DIVSRC_RST   = 1'h0;

   // watchdog_command_code values
   localparam logic [7:0] WDT_CODE_CLEAR   = 8'h4E;
   localparam logic [7:0] WDT_CODE_DISABLE = 8'hB1;
   localparam logic [7:0] WDT_CODE_TRAP    = 8'hD2;

   // divider: quarter-period tap is top tap minus twice the time select
   localparam int         WDT_DIV_W        = 23;
   localparam logic [4:0] WDT_HF_TAP_TOP   = 5'h16;
   localparam logic [4:0] WDT_LF_TAP_TOP   = 5'h0E;

   // reset pin low time in clock cycles
   localparam logic [4:0] WDT_RST_PULSE_CYCLES = 5'h18;

   typedef struct packed {
      logic                 cyc;
      logic                 stb;
      logic                 we;
      logic [WDT_ADR_W-1:0] adr;
      logic [3:0]           sel;
      logic [31:0]          dat;
   } wdt_wb_req_type;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } wdt_wb_rsp_type;

   typedef struct packed {
      logic hf_tick;
      logic lf_tick;
      logic slow_mode;
      logic hold_mode;
   } wdt_clk_ctl_type;

   typedef enum logic [2:0] {
      WDT_ST_RUN   = 3'b001,
      WDT_ST_OFF   = 3'b010,
      WDT_ST_RESET = 3'b100
   } wdt_state_type;

endpackage

// ==== rtl/wdt_divider.sv ====
`timescale 1ns/1ps
module wdt_divider
   import wdt_pkg::*;
#(
   parameter int DIV_W = WDT_DIV_W
) (
   input  wire logic       clk_i,      // system clock
   input  wire logic       rst_i,      // sync reset, active high
   input  wire logic       ce_i,       // clock enable
   input  wire logic       tick_i,     // selected source tick
   input  wire logic       hold_i,     // stop/idle/sleep freeze
   input  wire logic       use_lf_i,   // low-frequency tap set
   input  wire logic [1:0] tsel_i,     // detection time select
   output logic            quarter_o   // quarter-period pulse
);

   generate
      if (DIV_W < 23) begin : g_chk
         $error("wdt_divider: DIV_W too small for the longest period");
      end
   endgenerate

   logic [DIV_W-1:0] div_r;
   logic [DIV_W-1:0] low_mask;
   logic             adv;

   function automatic logic [4:0] tap_of(input logic lf, input logic [1:0] sel);
      logic [4:0] top;
      top = lf ? WDT_LF_TAP_TOP : WDT_HF_TAP_TOP;
      return top - {2'h0, sel, 1'b0};
   endfunction

   assign adv      = ce_i & tick_i & ~hold_i;
   assign low_mask = DIV_W'((64'h1 << (tap_of(use_lf_i, tsel_i) + 5'h1)) - 64'h1);
   // carry out of the tap bit marks one quarter of the detection period
   assign quarter_o = adv & ((div_r & low_mask) == low_mask);

   // never cleared by the clear code, so phase is kept
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_r <= '0;
      end else if (adv) begin
         div_r <= div_r + DIV_W'(1);
      end
   end

endmodule

// ==== rtl/wdt_wb_slave.sv ====
`timescale 1ns/1ps
module wdt_wb_slave
   import wdt_pkg::*;
(
   input  wire logic           clk_i,      // system clock
   input  wire logic           rst_i,      // sync reset, active high
   input  wire logic           ce_i,       // clock enable
   input  wire wdt_wb_req_type req_i,      // wishbone request
   input  wire logic [7:0]     rd_data_i,  // read data of addressed register
   output wdt_wb_rsp_type      rsp_o,      // wishbone answer
   output logic                wr_stb_o,   // write takes effect this edge
   output logic [7:0]          wr_idx_o,   // register index
   output logic [7:0]          wr_data_o   // write byte
);

   logic        ack_r;
   logic [31:0] dat_r;

   assign rsp_o     = '{ack: ack_r, dat: dat_r};
   assign wr_idx_o  = req_i.adr[WDT_ADR_W-1:2];
   assign wr_data_o = req_i.dat[7:0];
   // write lands on the same edge the master samples ack
   assign wr_stb_o  = ce_i & ack_r & req_i.cyc & req_i.stb & req_i.we & req_i.sel[0]
                      & (req_i.adr[1:0] == 2'h0);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
      end else if (ce_i) begin
         ack_r <= req_i.cyc & req_i.stb & ~ack_r;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_r <= '0;
      end else if (ce_i && req_i.cyc && req_i.stb && !ack_r) begin
         dat_r <= (req_i.we || req_i.adr[1:0] != 2'h0) ? 32'h0 : {24'h0, rd_data_i};
      end
   end

endmodule

// ==== verif/wdt_watchdog_timer_monitor.sv ====
`timescale 1ns/1ps
module wdt_watchdog_timer_monitor
   import wdt_pkg::*;
#(
   parameter int DIV_W = WDT_DIV_W
) (
   input wire logic            clk_i,                        // clock
   input wire logic            rst_i,                        // reset
   input wire logic            ce_i,                         // enable
   input wire wdt_wb_req_type  wb_req_i,                     // request
   input wire wdt_wb_rsp_type  wb_rsp_o,                     // answer
   input wire wdt_clk_ctl_type clk_ctl_i,                    // modes
   input wire logic            wdt_reset_n_o,                // reset pin
   input wire logic            watchdog_interrupt_request_o, // nmi
   input wire logic            ram_trap_area_o,              // trap area
   input wire logic            trap_action_o                 // trap action
);
   logic [5:0] low_cnt_r;
   logic       take;
   logic       trap_wr;
   assign take    = wb_req_i.cyc && wb_req_i.stb && ce_i;
   assign trap_wr = wb_rsp_o.ack && take && wb_req_i.we && wb_req_i.sel[0]
                    && wb_req_i.adr == 10'h0D4 && wb_req_i.dat[7:0] == WDT_CODE_TRAP;
   // length of the current low phase on the reset pin
   always_ff @(posedge clk_i) begin
      if (rst_i || wdt_reset_n_o) begin
         low_cnt_r <= 6'h00;
      end else begin
         low_cnt_r <= low_cnt_r + 6'h01;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   AST_ACK_TAKE: assert property (take && !wb_rsp_o.ack |=> wb_rsp_o.ack)
      else $error("request not answered");
   AST_ACK_PULSE: assert property (wb_rsp_o.ack && ce_i |=> !wb_rsp_o.ack)
      else $error("ack too long");
   AST_ACK_IDLE: assert property (!wb_req_i.stb && ce_i |=> !wb_rsp_o.ack)
      else $error("ack without request");
   AST_READ_ZERO:
      assert property (wb_rsp_o.ack && take && !wb_req_i.we && !(wb_req_i.adr inside
         {10'h0D8, 10'h0DC}) |-> wb_rsp_o.dat == 32'h00000000) else $error("read not zero");
   AST_IRQ_PULSE: assert property (watchdog_interrupt_request_o |=>
      !watchdog_interrupt_request_o [*8]) else $error("interrupt not a lone pulse");
   AST_RST_LEN: assert property ($rose(wdt_reset_n_o) |->
      low_cnt_r == {1'b0, WDT_RST_PULSE_CYCLES}) else $error("reset pulse length");
   AST_RST_REINIT: assert property ($rose(wdt_reset_n_o) |-> ##[0:1]
      (ram_trap_area_o && trap_action_o)) else $error("trap bits not reloaded");
   AST_HOLD: assert property (clk_ctl_i.hold_mode && $past(clk_ctl_i.hold_mode) |->
      !watchdog_interrupt_request_o && !$fell(wdt_reset_n_o)) else $error("overflow while held");
   AST_TRAP_COMMIT: assert property ($changed(ram_trap_area_o) |-> $past(trap_wr)
      || !$past(wdt_reset_n_o) || !$past(wdt_reset_n_o, 2)) else $error("trap area moved");
endmodule

bind wdt_watchdog_timer wdt_watchdog_timer_monitor #(.DIV_W(DIV_W)) i_mon (
   .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o),
   .clk_ctl_i(clk_ctl_i), .wdt_reset_n_o(wdt_reset_n_o),
   .watchdog_interrupt_request_o(watchdog_interrupt_request_o),
   .ram_trap_area_o(ram_trap_area_o), .trap_action_o(trap_action_o));

// ==== verif/wdt_cpu_model.sv ====
`timescale 1ns/1ps
module wdt_cpu_model
   import wdt_pkg::*;
(
   input  wire logic           clk_i,    // system clock
   input  wire wdt_wb_rsp_type wb_rsp_i, // slave answer
   output wdt_wb_req_type      wb_req_o  // bus request
);
   initial wb_req_o = '0;
   // whole-byte writes only, write-only registers are never read and merged
   task automatic access(input logic w, input logic [9:0] a, input logic [7:0] d,
                         output logic [7:0] q, output logic ok);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_req_o <= {1'b1, 1'b1, w, a, 4'hF, 24'h000000, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_rsp_i.ack !== 1'b1 && n < 40);
      ok = wb_rsp_i.ack;
      q = wb_rsp_i.dat[7:0];
      // idle lines carry the inverse so a stale value cannot pass for a valid one
      wb_req_o <= {2'b00, !w, ~a, 4'h0, ~{24'h000000, d}};
   endtask
   // clear first so the count is fresh when enable drops
   task automatic disable_wdt(input logic [7:0] ctrl, output logic ok);
      logic [7:0] q;
      logic [2:0] k;
      access(1'b1, 10'h0D4, WDT_CODE_CLEAR, q, k[0]);
      access(1'b1, 10'h0D0, ctrl & 8'hF7, q, k[1]);
      access(1'b1, 10'h0D4, WDT_CODE_DISABLE, q, k[2]);
      ok = &k;
   endtask
endmodule

// ==== verif/tb_wdt_watchdog_timer.sv ====
`timescale 1ns/1ps
module tb_wdt_watchdog_timer;
   import wdt_pkg::*;
   logic            clk_i = 1'b0;
   logic            rst_i = 1'b1;
   logic            ce = 1'b1;
   wdt_wb_req_type  wb_req;
   wdt_wb_rsp_type  wb_rsp;
   wdt_clk_ctl_type ctl = 4'hC;
   logic            rst_n;
   logic            irq;
   logic            t_area;
   logic            t_act;
   int              bad_count = 0;
   int              n_checks = 0;
   int              irq_seen = 0;
   int              cyc = 0;
   always #12.5 clk_i = ~clk_i;
   always @(posedge clk_i) cyc <= cyc + 1;
   always @(posedge clk_i) if (irq === 1'b1) irq_seen <= irq_seen + 1;
   wdt_watchdog_timer i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_req_i(wb_req),
      .wb_rsp_o(wb_rsp), .clk_ctl_i(ctl), .wdt_reset_n_o(rst_n),
      .watchdog_interrupt_request_o(irq), .ram_trap_area_o(t_area), .trap_action_o(t_act));
   wdt_cpu_model i_cpu (.clk_i(clk_i), .wb_rsp_i(wb_rsp), .wb_req_o(wb_req));
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask
   task automatic acc(input logic w, input logic [9:0] a, input logic [7:0] d,
                      input logic [7:0] m);
      logic [7:0] q;
      logic       ok;
      i_cpu.access(w, a, d, q, ok);
      if (ok !== 1'b1) begin
         check(16'h0000, 16'h0001, "no bus answer");
         test_done();
      end
      if (!w) check({8'h00, q & m}, {8'h00, d & m}, "read data");
   endtask
   task automatic wait_for(input int which, input int lim, output int n);
      logic hit;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
         hit = which == 0 ? irq : which == 1 ? !rst_n : rst_n;
      end while (hit !== 1'b1 && n < lim);
      if (hit !== 1'b1) begin
         check(16'h0000, 16'h0001, "wait ran out");
         test_done();
      end
   endtask
   task automatic do_reset();
      rst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask
   task automatic s_reset_values();
      acc(1'b0, 10'h0DC, 8'h49, 8'hFF);
      acc(1'b0, 10'h0D0, 8'h00, 8'hFF);
      acc(1'b0, 10'h0D4, 8'h00, 8'hFF);
      acc(1'b0, 10'h100, 8'h00, 8'hFF);
      check({14'h0000, t_area, t_act}, 16'h0003, "trap reset");
   endtask
   task automatic s_disable();
      logic ok;
      acc(1'b1, 10'h0D4, WDT_CODE_DISABLE, 8'h00);
      acc(1'b0, 10'h0DC, 8'h49, 8'hFF);
      acc(1'b1, 10'h0D0, 8'h31, 8'h00);
      acc(1'b0, 10'h0DC, 8'h09, 8'hFF);
      i_cpu.disable_wdt(8'h31, ok);
      check({15'h0000, ok}, 16'h0001, "disable answered");
      acc(1'b0, 10'h0DC, 8'h0A, 8'hFF);
      acc(1'b1, 10'h0D0, 8'h09, 8'h00);
      acc(1'b1, 10'h0D4, 8'h55, 8'h00);
      check({14'h0000, t_area, t_act}, 16'h0002, "trap pending");
      acc(1'b1, 10'h0D4, WDT_CODE_TRAP, 8'h00);
      acc(1'b0, 10'h0DC, 8'h49, 8'hFF);
      check({14'h0000, t_area, t_act}, 16'h0000, "trap commit");
   endtask
   task automatic s_irq();
      int n;
      int t0;
      int m;
      acc(1'b1, 10'h0D8, 8'h10, 8'h00);
      acc(1'b0, 10'h0D8, 8'h10, 8'hFF);
      acc(1'b1, 10'h0D0, 8'h3E, 8'h00);
      acc(1'b1, 10'h0D0, 8'h3F, 8'h00);
      acc(1'b0, 10'h0DC, 8'h41, 8'hCF);
      wait_for(0, 2200, n);
      t0 = cyc;
      acc(1'b1, 10'h0D4, WDT_CODE_CLEAR, 8'h00);
      wait_for(0, 2200, n);
      check(16'(cyc - t0), 16'h0800, "period after early clear");
      repeat (100) @(posedge clk_i);
      ctl.hold_mode <= 1'b1;
      repeat (3000) @(posedge clk_i);
      ctl.hold_mode <= 1'b0;
      wait_for(0, 2200, n);
      check(n[15:0], 16'h079C, "count across hold");
      @(posedge clk_i);
      m = irq_seen;
      // clear before a stop and again right after it
      acc(1'b1, 10'h0D4, WDT_CODE_CLEAR, 8'h00);
      ctl.hold_mode <= 1'b1;
      repeat (3000) @(posedge clk_i);
      ctl.hold_mode <= 1'b0;
      repeat (6) begin
         acc(1'b1, 10'h0D4, WDT_CODE_CLEAR, 8'h00);
         repeat (1000) @(posedge clk_i);
      end
      check(16'(irq_seen - m), 16'h0000, "overflow despite clears");
      acc(1'b1, 10'h0D4, WDT_CODE_CLEAR, 8'h00);
      wait_for(0, 2200, n);
      check({15'h0000, n > 1530 && n < 2050}, 16'h0001, "clear to overflow");
   endtask
   task automatic s_ovf();
      int n;
      do_reset();
      acc(1'b1, 10'h0D8, 8'h10, 8'h00);
      acc(1'b1, 10'h0D0, 8'h3F, 8'h00);
      // clock enable low must hold divider and counter still
      ce <= 1'b0;
      repeat (1000) @(posedge clk_i);
      ce <= 1'b1;
      wait_for(1, 2200, n);
      // 2048 ticks to overflow, six spent before the freeze, one for the pin flop
      check(n[15:0], 16'h07FB, "overflow time across freeze");
      wait_for(2, 100, n);
      check(n[15:0], {11'h000, WDT_RST_PULSE_CYCLES}, "reset low time");
      acc(1'b0, 10'h0DC, 8'h49, 8'hFF);
      acc(1'b0, 10'h0D8, 8'h00, 8'hFF);
   endtask
   initial begin
      do_reset();
      s_reset_values();
      s_disable();
      s_irq();
      s_ovf();
      test_done();
   end
endmodule
